// [scrb_cfg.svh]
// named offsets, field positions, reset values and counts for the serial config bank
`ifndef SCRB_CFG_SVH
`define SCRB_CFG_SVH

`define SCRB_ADDR_CFG_A   15'h0000
`define SCRB_ADDR_CFG_B   15'h0001
`define SCRB_ADDR_PWR     15'h0002

`define SCRB_BIT_SRST     0
`define SCRB_BIT_LSB      1
`define SCRB_BIT_INC      2
`define SCRB_BIT_INC_M    5
`define SCRB_BIT_LSB_M    6
`define SCRB_BIT_SRST_M   7
`define SCRB_BIT_DP_RST   1
`define SCRB_BIT_RW       15

`define SCRB_PWR_NORMAL   2'h0
`define SCRB_PWR_STANDBY  2'h2
`define SCRB_PWR_DOWN     2'h3

`define SCRB_BYTE_ZERO    8'h00
`define SCRB_CNT_ZERO     4'h0
`define SCRB_CNT_ONE      4'h1
`define SCRB_INSTR_LAST   4'hf
`define SCRB_BYTE_LAST    4'h7
`define SCRB_CH_A         0
`define SCRB_CH_B         1

`endif

// [scrb_cfg_bank_sva.sv]
// checker for the serial config bank output relations
`timescale 1ns/1ns
`default_nettype none
module scrb_cfg_bank_sva (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       csb_n,
  input wire logic       sdio_oe,
  input wire logic       lsb_first,
  input wire logic       addr_ascend,
  input wire logic       soft_reset_pulse,
  input wire logic       datapath_reset_pulse,
  input wire logic [1:0] dp_clock_stop,
  input wire logic [1:0] dp_reset_hold,
  input wire logic [1:0] link_enable
);
  // ****************
  // assertions
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  hold_chan_a_a: assert property (dp_reset_hold[0] |-> dp_clock_stop[0] && !link_enable[0])
    else $error("channel a power-down outputs disagree");
  hold_chan_b_a: assert property (dp_reset_hold[1] |-> dp_clock_stop[1] && !link_enable[1])
    else $error("channel b power-down outputs disagree");
  standby_link_a: assert property ((link_enable | dp_reset_hold) == 2'h3)
    else $error("link dropped outside power-down");
  srst_clears_a: assert property (soft_reset_pulse |-> ##[0:2] (!lsb_first && !addr_ascend &&
    dp_clock_stop == 2'h0 && link_enable == 2'h3)) else $error("soft reset left fields set");
  srst_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  dp_pulse_a: assert property (datapath_reset_pulse |=> !datapath_reset_pulse)
    else $error("datapath reset pulse too long");
  dp_only_a: assert property (datapath_reset_pulse |=> $stable(dp_reset_hold) && $stable(link_enable))
    else $error("datapath reset touched power outputs");
  // idle port must not move the format fields
  cfg_idle_a: assert property (csb_n [*8] |=> $stable(lsb_first) && $stable(addr_ascend))
    else $error("format fields changed while deselected");
  srst_cov: cover property (soft_reset_pulse);
  dp_cov: cover property (datapath_reset_pulse);
  down_cov: cover property (dp_reset_hold == 2'h3);
  read_cov: cover property ($rose(sdio_oe));
endmodule : scrb_cfg_bank_sva
bind scrb_spi_config_bank scrb_cfg_bank_sva i_scrb_cfg_bank_sva (.*);
`default_nettype wire

// [scrb_pkg.sv]
// types shared by the serial config bank
`default_nettype none
package scrb_pkg;
  typedef enum logic [1:0] {
    SCRB_IDLE,
    SCRB_INSTR,
    SCRB_DATA
  } scrb_phase_t;
endpackage : scrb_pkg
`default_nettype wire

// [scrb_spi_config_bank.sv]
// serial port configuration registers behind a three-wire serial port
//
// Behaviour
// - soft reset bit or mirror resets everything
// - bit order field selects lsb or msb first
// - address field selects increment or decrement stepping
// - configuration fields reset to zero
// - datapath reset bit pulses, then self clears
// - power field: normal, standby stops clocks
// - power-down stops clocks, holds reset, disables link
// - power field per channel, read returns A unless only B is selected
`timescale 1ns/1ns
`default_nettype none
`include "scrb_cfg.svh"

module scrb_spi_config_bank (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       sclk,
  input  wire logic       csb_n,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  input  wire logic [1:0] channel_select,
  output logic            lsb_first,
  output logic            addr_ascend,
  output logic            soft_reset_pulse,
  output logic            datapath_reset_pulse,
  output logic [1:0]      dp_clock_stop,
  output logic [1:0]      dp_reset_hold,
  output logic [1:0]      link_enable
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [15:0] scrb_shift(input logic [15:0] sh, input logic b,
                                             input logic lsb, input logic is_byte);
    logic [15:0] r;
    r = {sh[14:0], b};
    if (lsb) begin
      r = is_byte ? {`SCRB_BYTE_ZERO, b, sh[7:1]} : {b, sh[15:1]};
    end
    return r;
  endfunction : scrb_shift

  function automatic logic [14:0] scrb_step(input logic [14:0] a, input logic inc);
    return inc ? a + 15'h0001 : a - 15'h0001;
  endfunction : scrb_step

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclk_s_r;
  logic [2:0] csb_s_r;
  logic [2:0] sdi_s_r;
  logic       sclk_f_r;
  logic       csb_f_r;
  logic       sdi_f_r;

  // filtered level only moves when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s_r <= 3'h0;
      csb_s_r  <= 3'h7;
      sdi_s_r  <= 3'h0;
      sclk_f_r <= 1'b0;
      csb_f_r  <= 1'b1;
      sdi_f_r  <= 1'b0;
    end else if (clk_en) begin
      sclk_s_r <= {sclk_s_r[1:0], sclk};
      csb_s_r  <= {csb_s_r[1:0], csb_n};
      sdi_s_r  <= {sdi_s_r[1:0], sdio_in};
      if (sclk_s_r[1] == sclk_s_r[2]) sclk_f_r <= sclk_s_r[2];
      if (csb_s_r[1] == csb_s_r[2]) csb_f_r <= csb_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2]) sdi_f_r <= sdi_s_r[2];
    end
  end

  logic sclk_nxt;
  logic csb_nxt;
  assign sclk_nxt = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_f_r;
  assign csb_nxt  = (csb_s_r[1] == csb_s_r[2]) ? csb_s_r[2] : csb_f_r;

  logic sclk_rise;
  logic sclk_fall;
  logic csb_fall;
  assign sclk_rise = sclk_nxt & ~sclk_f_r & ~csb_f_r;
  assign sclk_fall = ~sclk_nxt & sclk_f_r & ~csb_f_r;
  assign csb_fall  = ~csb_nxt & csb_f_r;

  // ****************************************
  // register storage
  // ****************************************
  logic       lsb_r;       // one bit for primary and mirror
  logic       inc_r;
  logic [1:0] pwr_r [2];
  logic       srst_r;
  logic       dp_rst_r;

  // ****************************************
  // frame sequencer
  // ****************************************
  scrb_pkg::scrb_phase_t phase_r;
  logic [3:0]            cnt_r;
  logic [15:0]           sh_r;
  logic [14:0]           addr_r;
  logic                  rd_r;
  logic [15:0]           sh_nxt;
  logic                  byte_done;
  logic                  instr_done;
  logic                  wr_stb;
  logic [7:0]            wr_byte;

  assign sh_nxt     = scrb_shift(sh_r, sdi_f_r, lsb_r, phase_r == scrb_pkg::SCRB_DATA);
  assign instr_done = sclk_rise && phase_r == scrb_pkg::SCRB_INSTR && cnt_r == `SCRB_INSTR_LAST;
  assign byte_done  = sclk_rise && phase_r == scrb_pkg::SCRB_DATA && cnt_r == `SCRB_BYTE_LAST;
  assign wr_stb     = byte_done && !rd_r;
  assign wr_byte    = sh_nxt[7:0];

  // soft reset clears the port state one cycle after the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= scrb_pkg::SCRB_IDLE;
      cnt_r   <= `SCRB_CNT_ZERO;
      sh_r    <= 16'h0000;
      addr_r  <= 15'h0000;
      rd_r    <= 1'b0;
    end else if (clk_en) begin
      if (srst_r || csb_f_r) begin
        phase_r <= scrb_pkg::SCRB_IDLE;
        cnt_r   <= `SCRB_CNT_ZERO;
      end else begin
        case (phase_r)
          scrb_pkg::SCRB_IDLE: begin
            if (csb_fall || !csb_f_r) begin
              phase_r <= scrb_pkg::SCRB_INSTR;
              cnt_r   <= `SCRB_CNT_ZERO;
              sh_r    <= 16'h0000;
            end
          end
          scrb_pkg::SCRB_INSTR: begin
            if (sclk_rise) begin
              sh_r  <= sh_nxt;
              cnt_r <= cnt_r + `SCRB_CNT_ONE;
              if (instr_done) begin
                rd_r    <= sh_nxt[`SCRB_BIT_RW];
                addr_r  <= sh_nxt[14:0];
                phase_r <= scrb_pkg::SCRB_DATA;
                cnt_r   <= `SCRB_CNT_ZERO;
                sh_r    <= 16'h0000;
              end
            end
          end
          scrb_pkg::SCRB_DATA: begin
            if (sclk_rise) begin
              sh_r  <= sh_nxt;
              cnt_r <= cnt_r + `SCRB_CNT_ONE;
              if (byte_done) begin
                cnt_r  <= `SCRB_CNT_ZERO;
                sh_r   <= 16'h0000;
                addr_r <= scrb_step(addr_r, inc_r);
              end
            end
          end
          default: phase_r <= scrb_pkg::SCRB_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // unsupported addresses fall through and are dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsb_r    <= 1'b0;
      inc_r    <= 1'b0;
      pwr_r[0] <= `SCRB_PWR_NORMAL;
      pwr_r[1] <= `SCRB_PWR_NORMAL;
      srst_r   <= 1'b0;
      dp_rst_r <= 1'b0;
    end else if (clk_en) begin
      srst_r   <= 1'b0;
      dp_rst_r <= 1'b0;
      if (srst_r) begin
        lsb_r    <= 1'b0;
        inc_r    <= 1'b0;
        pwr_r[0] <= `SCRB_PWR_NORMAL;
        pwr_r[1] <= `SCRB_PWR_NORMAL;
      end else if (wr_stb) begin
        case (addr_r)
          `SCRB_ADDR_CFG_A: begin
            if (wr_byte[`SCRB_BIT_SRST] || wr_byte[`SCRB_BIT_SRST_M]) begin
              srst_r <= 1'b1;
            end else begin
              lsb_r <= wr_byte[`SCRB_BIT_LSB] | wr_byte[`SCRB_BIT_LSB_M];
              inc_r <= wr_byte[`SCRB_BIT_INC] | wr_byte[`SCRB_BIT_INC_M];
            end
          end
          `SCRB_ADDR_CFG_B: begin
            dp_rst_r <= wr_byte[`SCRB_BIT_DP_RST];
          end
          `SCRB_ADDR_PWR: begin
            if (channel_select[`SCRB_CH_A]) pwr_r[0] <= wr_byte[1:0];
            if (channel_select[`SCRB_CH_B]) pwr_r[1] <= wr_byte[1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // readback
  // ****************************************
  logic [14:0] rd_addr;
  logic [7:0]  rd_byte;
  logic [1:0]  rd_pwr;
  assign rd_addr = instr_done ? sh_nxt[14:0] : scrb_step(addr_r, inc_r);
  // both selected, or none, answers with channel A
  assign rd_pwr  = (channel_select == 2'h2) ? pwr_r[1] : pwr_r[0];

  always_comb begin
    rd_byte = `SCRB_BYTE_ZERO;
    case (rd_addr)
      `SCRB_ADDR_CFG_A: begin
        rd_byte[`SCRB_BIT_LSB]   = lsb_r;
        rd_byte[`SCRB_BIT_LSB_M] = lsb_r;
        rd_byte[`SCRB_BIT_INC]   = inc_r;
        rd_byte[`SCRB_BIT_INC_M] = inc_r;
      end
      `SCRB_ADDR_PWR: rd_byte[1:0] = rd_pwr;
      default: rd_byte = `SCRB_BYTE_ZERO;
    endcase
  end

  logic [7:0] tx_r;
  logic       rd_go;
  assign rd_go = (instr_done && sh_nxt[`SCRB_BIT_RW]) || (byte_done && rd_r);

  // data leaves on falling edges so the host samples it on the next rise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r     <= `SCRB_BYTE_ZERO;
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else if (clk_en) begin
      if (csb_f_r || srst_r) begin
        sdio_oe <= 1'b0;
      end else if (rd_go) begin
        tx_r <= rd_byte;
      end else if (sclk_fall && phase_r == scrb_pkg::SCRB_DATA && rd_r) begin
        sdio_oe  <= 1'b1;
        sdio_out <= lsb_r ? tx_r[0] : tx_r[7];
        tx_r     <= lsb_r ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // registered control outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsb_first            <= 1'b0;
      addr_ascend          <= 1'b0;
      soft_reset_pulse     <= 1'b0;
      datapath_reset_pulse <= 1'b0;
      dp_clock_stop        <= 2'h0;
      dp_reset_hold        <= 2'h0;
      link_enable          <= 2'h3;
    end else if (clk_en) begin
      lsb_first            <= lsb_r;
      addr_ascend          <= inc_r;
      soft_reset_pulse     <= srst_r;
      datapath_reset_pulse <= dp_rst_r;
      for (int ch = 0; ch < 2; ch++) begin
        // code 01 is undefined and treated as normal
        dp_clock_stop[ch] <= pwr_r[ch] == `SCRB_PWR_STANDBY || pwr_r[ch] == `SCRB_PWR_DOWN;
        dp_reset_hold[ch] <= pwr_r[ch] == `SCRB_PWR_DOWN;
        link_enable[ch]   <= pwr_r[ch] != `SCRB_PWR_DOWN;
      end
    end
  end

endmodule : scrb_spi_config_bank
`default_nettype wire

// [scrb_spi_config_bank_tb.sv]
// self-checking bench for the serial config bank
`timescale 1ns/1ns
`default_nettype none
module scrb_spi_config_bank_tb;
  logic        ref_clk, rst_n, clk_en, host_lsb, sclk, csb_n, sdo, sdio_out, sdio_oe;
  logic        lsb_first, addr_ascend, srst_p, dprst_p;
  logic [1:0]  chsel, clock_stop, hold, link;
  logic [1:0]  pw [2];
  logic [15:0] rx;
  int          miscompares, tests_run, srst_cnt, dp_cnt, c;
  wire         sdio = sdio_oe ? sdio_out : sdo;
  scrb_spi_config_bank i_scrb_spi_config_bank (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .channel_select(chsel), .lsb_first(lsb_first), .addr_ascend(addr_ascend),
    .soft_reset_pulse(srst_p), .datapath_reset_pulse(dprst_p), .dp_clock_stop(clock_stop),
    .dp_reset_hold(hold), .link_enable(link));
  scrb_spi_host i_scrb_spi_host (.ref_clk(ref_clk), .lsb(host_lsb), .sdi(sdio), .sclk(sclk),
    .csb_n(csb_n), .sdo(sdo));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (srst_p === 1'b1) srst_cnt++;
    if (dprst_p === 1'b1) dp_cnt++;
  end
  // ****************
  // access tasks
  // ****************
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    i_scrb_spi_host.xfer(1'b0, a, {d, 8'h00}, 1, rx);
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] e, input string what);
    i_scrb_spi_host.xfer(1'b1, a, 16'h0000, 1, rx);
    check(what, rx[15:8], e);
  endtask : rd
  task automatic pwr(input logic [1:0] sel, input logic [7:0] d);
    int k;
    chsel = sel;
    wr(15'h0002, d);
    for (k = 0; k < 2; k++) if (sel[k]) pw[k] = d[1:0];
    for (k = 0; k < 2; k++) begin
      check("clock_stop", {7'h00, clock_stop[k]}, {7'h00, pw[k][1]});
      check("hold", {7'h00, hold[k]}, {7'h00, &pw[k]});
      check("link", {7'h00, link[k]}, {7'h00, ~&pw[k]});
    end
  endtask : pwr
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
  initial begin
    {ref_clk, rst_n, host_lsb, miscompares, tests_run, srst_cnt, dp_cnt} = '0;
    clk_en = 1'b1;
    chsel = 2'h3;
    pw[0] = 2'h0;
    pw[1] = 2'h0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    rd(15'h0000, 8'h00, "cfg_a");
    check("order", {7'h00, lsb_first}, 8'h00);
    for (c = 0; c < 4; c++) pwr(2'h3, 8'(c));
    pwr(2'h1, 8'h02);
    pwr(2'h2, 8'h00);
    chsel = 2'h3;
    rd(15'h0002, 8'h02, "pwr_both");
    chsel = 2'h2;
    rd(15'h0002, 8'h00, "pwr_b");
    pwr(2'h3, 8'hfc);
    rd(15'h0002, 8'h00, "pwr_rsv");
    pwr(2'h3, 8'h03);
    wr(15'h0001, 8'hff);
    check("dp_pulses", dp_cnt[7:0], 8'h01);
    rd(15'h0001, 8'h00, "cfg_b");
    rd(15'h0002, 8'h03, "pwr_kept");
    clk_en = 1'b0;
    wr(15'h0002, 8'h00); // frozen port must miss this
    clk_en = 1'b1;
    rd(15'h0002, 8'h03, "frozen");
    wr(15'h0000, 8'h38);
    check("ascend", {7'h00, addr_ascend}, 8'h01);
    rd(15'h0000, 8'h24, "mirror");
    i_scrb_spi_host.xfer(1'b0, 15'h0001, 16'h0002, 2, rx);
    rd(15'h0002, 8'h02, "asc_step");
    wr(15'h0000, 8'h00);
    i_scrb_spi_host.xfer(1'b0, 15'h0002, 16'h0302, 2, rx);
    check("dsc_dp", dp_cnt[7:0], 8'h02);
    rd(15'h0002, 8'h03, "dsc_step");
    wr(15'h0000, 8'h42);
    check("lsb", {7'h00, lsb_first}, 8'h01);
    host_lsb = 1'b1;
    wr(15'h0002, 8'h03);
    rd(15'h0002, 8'h03, "lsb_pwr");
    rd(15'h0000, 8'h42, "lsb_cfg");
    wr(15'h0000, 8'h80);
    host_lsb = 1'b0;
    check("srst_pulses", srst_cnt[7:0], 8'h01);
    check("hold_clr", {6'h00, hold}, 8'h00);
    rd(15'h0000, 8'h00, "srst_cfg");
    rd(15'h0002, 8'h00, "srst_pwr"); // only reads in the recovery time
    conclude();
  end
endmodule : scrb_spi_config_bank_tb
`default_nettype wire

// [scrb_spi_host.sv]
// serial host model that frames reads and writes to the config bank
`timescale 1ns/1ns
`default_nettype none
module scrb_spi_host (
  input  wire logic ref_clk,
  input  wire logic lsb,
  input  wire logic sdi,
  output var logic  sclk,
  output var logic  csb_n,
  output var logic  sdo
);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdo = 1'b0;
  end
  // ****************
  // one bit: change in low phase, sample at rise
  // ****************
  task automatic shift(input logic d, input logic drv, output logic q);
    sdo = drv ? d : ~sdo; // released line toggles so stale data never passes
    repeat (6) @(negedge ref_clk);
    q = sdi;
    sclk = 1'b1;
    repeat (5) @(negedge ref_clk);
    sclk = 1'b0;
  endtask : shift
  // ****************
  // frame: byte k of wd and q sits at [15-8k -: 8]
  // ****************
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd, input int n,
                      output logic [15:0] q);
    logic [15:0] ins;
    logic        b;
    int          i;
    int          k;
    ins = {rd, a};
    q = 16'h0000;
    csb_n = 1'b0;
    for (i = 0; i < 16; i++) shift(ins[lsb ? i : 15 - i], 1'b1, b);
    for (i = 0; i < 8 * n; i++) begin
      k = 8 * (1 - i / 8) + (lsb ? i % 8 : 7 - i % 8);
      shift(wd[k], !rd, q[k]);
    end
    repeat (5) @(negedge ref_clk);
    csb_n = 1'b1;
    repeat (10) @(negedge ref_clk);
  endtask : xfer
endmodule : scrb_spi_host
`default_nettype wire
